//--- rtl/smsps_map.vh
// constants, register map and encodings of the servo mode select and position scaling block
`ifndef SMSPS_MAP_VH
`define SMSPS_MAP_VH
// control mode codes
`define SMSPS_MODE_PT 4'h0
`define SMSPS_MODE_PR 4'h1
`define SMSPS_MODE_V 4'h2
`define SMSPS_MODE_T 4'h3
`define SMSPS_MODE_VZ 4'h4
`define SMSPS_MODE_TZ 4'h5
`define SMSPS_MODE_PT_V 4'h6
`define SMSPS_MODE_PT_T 4'h7
`define SMSPS_MODE_PR_V 4'h8
`define SMSPS_MODE_PR_T 4'h9
`define SMSPS_MODE_V_T 4'ha
// active control loop select codes
`define SMSPS_LOOP_POS_PULSE 3'h0
`define SMSPS_LOOP_POS_PRESET 3'h1
`define SMSPS_LOOP_VEL 3'h2
`define SMSPS_LOOP_TRQ 3'h3
// pulse formats
`define SMSPS_FMT_QUAD 2'h0
`define SMSPS_FMT_STEP_DIR 2'h1
`define SMSPS_FMT_CW_CCW 2'h2
// register byte offsets
`define SMSPS_REG_MODE 12'h000
`define SMSPS_REG_GEAR_NUM 12'h004
`define SMSPS_REG_GEAR_DEN 12'h008
`define SMSPS_REG_LOWPASS 12'h00c
`define SMSPS_REG_SCURVE_A 12'h010
`define SMSPS_REG_SCURVE_B 12'h014
`define SMSPS_REG_SCURVE_C 12'h018
`define SMSPS_REG_CONFIG 12'h01c
`define SMSPS_REG_STATUS 12'h020
`define SMSPS_REG_TARGET 12'h024
`define SMSPS_REG_CMD 12'h028
`define SMSPS_REG_PRESET_BASE 12'h040
`define SMSPS_REG_PRESET_LAST 12'h07c
// field positions and reset values
`define SMSPS_CFG_FMT_LSB 0
`define SMSPS_CFG_FMT_MSB 1
`define SMSPS_CFG_INCR 2
`define SMSPS_GEAR_RESET 16'h0001
`define SMSPS_COUNTS_PER_REV 32'h00002710
`define SMSPS_AXI_OKAY 2'h0
`define SMSPS_AXI_SLVERR 2'h2
`endif

//--- rtl/smsps_gear.v
// electronic gear scaler: each pulse adds num/den counts with remainder carried
`timescale 1ns/10ps
module smsps_gear (
    // clock and reset
    input wire clock,
    input wire nrst,
    // ratio
    input wire [15:0] gear_numerator,
    input wire [15:0] gear_denominator,
    // one command pulse in
    input wire pulse,
    input wire dir_neg,
    // scaled step out
    output reg step_valid,
    output reg signed [31:0] step_counts
);
    reg [16:0] rem;
    reg [16:0] acc;
    reg [15:0] whole;
    reg [16:0] next_rem;
    integer i;

    // repeated subtraction bounded by 256 iterations, a 256:1 ratio limit the host must keep
    always @* begin
        acc = rem + {1'b0, gear_numerator};
        whole = 16'h0000;
        for (i = 0; i < 256; i = i + 1) begin
            if (gear_denominator != 16'h0000 && acc >= {1'b0, gear_denominator}) begin
                acc = acc - {1'b0, gear_denominator};
                whole = whole + 16'h0001;
            end
        end
        next_rem = acc;
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rem <= 17'h00000;
            step_valid <= 1'b0;
            step_counts <= 32'sh00000000;
        end else begin
            step_valid <= pulse;
            if (pulse) begin
                rem <= next_rem;
                step_counts <= dir_neg ? -$signed({16'h0000, whole}) :
                    $signed({16'h0000, whole});
            end
        end
    end
endmodule // smsps_gear

//--- rtl/smsps_top.v
// mode selection and position command scaling with an axi4-lite register slave
`timescale 1ns/10ps
`include "smsps_map.vh"

// How it works
// - mode 00 takes position from pulses: quadrature, step/direction or cw/ccw.
// - mode 01 takes position from one of eight stored presets chosen by inputs.
// - mode 02 is velocity control from analog or three setpoints by inputs.
// - mode 04 is velocity control from three internal setpoints only.
// - mode 03 is torque control from analog or three presets by inputs.
// - mode 05 is torque control from three internal presets only.
// - dual codes 06,07,09,10 swap two single modes under a digital input.
// - code 08 swaps preset position and velocity under a digital input.
// - a written mode code becomes active only after a power cycle.
// - every position preset is writable over the axi4-lite register port.
// - both position modes are scaled by numerator over denominator.
// - each pulse advances the target by ratio counts, 10000 counts per rev.
// - linear ramp over the s-curve time for preset moves only; low-pass for both.
// - preset moves start on the trigger input rising edge.
// - three select inputs form a binary index, top input most significant.
// - a low-pass setting of zero passes commands through.
module smsps_top (
    // clock and reset
    input wire clock,
    input wire nrst,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // command pulse inputs
    input wire pulse_a,
    input wire pulse_b,
    // digital inputs
    input wire servo_enable,
    input wire mode_switch_input,
    input wire command_trigger_input,
    input wire [2:0] preset_select_inputs,
    input wire [1:0] setpoint_select_inputs,
    // outputs to the control loops
    output reg [2:0] active_loop,
    output reg use_analog_command,
    output reg [1:0] setpoint_index,
    output reg signed [31:0] position_command,
    output reg move_busy
);
    // register storage
    reg [3:0] mode_code_setting = `SMSPS_MODE_PT;
    reg [3:0] active_mode;
    reg mode_latched;
    reg [15:0] gear_numerator;
    reg [15:0] gear_denominator;
    reg [15:0] position_lowpass_setting;
    reg [15:0] scurve_setting_a;
    reg [15:0] scurve_setting_b;
    reg [15:0] scurve_setting_c;
    reg [2:0] config_bits;
    reg [31:0] preset_mem [0:15];
    // datapath state
    reg signed [31:0] raw_target;
    reg signed [31:0] move_start;
    reg signed [31:0] move_goal;
    reg [15:0] ramp_count;
    reg pa_q;
    reg pb_q;
    reg trig_q;
    reg [11:0] wa_addr;
    reg [31:0] wa_data;
    reg [3:0] wa_strb;
    reg have_aw;
    reg have_w;
    // move sequencer, one-hot
    localparam [2:0] st_idle = 3'b001;
    localparam [2:0] st_ramp = 3'b010;
    localparam [2:0] st_hold = 3'b100;
    reg [2:0] state;

    function is_preset;
        input [11:0] a;
        begin
            is_preset = (a >= `SMSPS_REG_PRESET_BASE) && (a <= `SMSPS_REG_PRESET_LAST);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] d;
        input [3:0] s;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (s[k]) begin
                    merge[k*8 +: 8] = d[k*8 +: 8];
                end
            end
        end
    endfunction

    // mode decode: pick loop for the frozen mode code and the dual-switch input
    reg [2:0] next_loop;
    reg next_analog;
    always @* begin
        next_analog = 1'b0;
        case (active_mode)
            `SMSPS_MODE_PT: next_loop = `SMSPS_LOOP_POS_PULSE;
            `SMSPS_MODE_PR: next_loop = `SMSPS_LOOP_POS_PRESET;
            `SMSPS_MODE_V: begin
                next_loop = `SMSPS_LOOP_VEL;
                next_analog = (setpoint_select_inputs == 2'h0);
            end
            `SMSPS_MODE_VZ: next_loop = `SMSPS_LOOP_VEL;
            `SMSPS_MODE_T: begin
                next_loop = `SMSPS_LOOP_TRQ;
                next_analog = (setpoint_select_inputs == 2'h0);
            end
            `SMSPS_MODE_TZ: next_loop = `SMSPS_LOOP_TRQ;
            `SMSPS_MODE_PT_V: next_loop = mode_switch_input ? `SMSPS_LOOP_VEL :
                `SMSPS_LOOP_POS_PULSE;
            `SMSPS_MODE_PT_T: next_loop = mode_switch_input ? `SMSPS_LOOP_TRQ :
                `SMSPS_LOOP_POS_PULSE;
            `SMSPS_MODE_PR_V: next_loop = mode_switch_input ? `SMSPS_LOOP_VEL :
                `SMSPS_LOOP_POS_PRESET;
            `SMSPS_MODE_PR_T: next_loop = mode_switch_input ? `SMSPS_LOOP_TRQ :
                `SMSPS_LOOP_POS_PRESET;
            `SMSPS_MODE_V_T: next_loop = mode_switch_input ? `SMSPS_LOOP_TRQ :
                `SMSPS_LOOP_VEL;
            default: next_loop = `SMSPS_LOOP_POS_PULSE;
        endcase
        if (next_loop != `SMSPS_LOOP_VEL && next_loop != `SMSPS_LOOP_TRQ) begin
            next_analog = 1'b0;
        end
    end

    // pulse decoder: one count per qualifying edge of the chosen format
    reg cmd_pulse;
    reg cmd_neg;
    always @* begin
        cmd_pulse = 1'b0;
        cmd_neg = 1'b0;
        case (config_bits[`SMSPS_CFG_FMT_MSB:`SMSPS_CFG_FMT_LSB])
            `SMSPS_FMT_QUAD: begin
                cmd_pulse = (pulse_a ^ pa_q) | (pulse_b ^ pb_q);
                cmd_neg = (pulse_a ^ pa_q) ? (pulse_a == pulse_b) : (pulse_a != pulse_b);
            end
            `SMSPS_FMT_STEP_DIR: begin
                cmd_pulse = pulse_a & ~pa_q;
                cmd_neg = pulse_b;
            end
            `SMSPS_FMT_CW_CCW: begin
                cmd_pulse = (pulse_a & ~pa_q) ^ (pulse_b & ~pb_q);
                cmd_neg = pulse_b & ~pb_q;
            end
            default: cmd_pulse = 1'b0;
        endcase
        cmd_pulse = cmd_pulse & servo_enable & (next_loop == `SMSPS_LOOP_POS_PULSE);
    end

    // preset index and target in counts
    wire [3:0] pidx = {preset_select_inputs, 1'b0};
    wire signed [31:0] preset_rev = preset_mem[pidx];
    wire signed [31:0] preset_frac = preset_mem[pidx + 4'h1];
    wire signed [63:0] preset_counts_w = preset_rev * $signed(`SMSPS_COUNTS_PER_REV) +
        preset_frac;
    wire trig_rise = command_trigger_input & ~trig_q;

    // gear both sources: pulses through the scaler, presets by full multiply
    wire gear_valid;
    wire signed [31:0] gear_step;
    smsps_gear u_gear (
        .clock(clock),
        .nrst(nrst),
        .gear_numerator(gear_numerator),
        .gear_denominator(gear_denominator),
        .pulse(cmd_pulse),
        .dir_neg(cmd_neg),
        .step_valid(gear_valid),
        .step_counts(gear_step)
    );
    wire signed [63:0] preset_scaled_w = (preset_counts_w *
        $signed({16'h0000, gear_numerator})) /
        $signed({16'h0000, (gear_denominator == 16'h0000) ? 16'h0001 : gear_denominator});
    wire signed [31:0] preset_scaled = preset_scaled_w[31:0];
    wire signed [31:0] preset_goal = config_bits[`SMSPS_CFG_INCR] ?
        raw_target + preset_scaled : preset_scaled;

    // s-curve length in cycles; low-pass shift from the lowpass setting
    wire [15:0] ramp_len = scurve_setting_a + scurve_setting_b + scurve_setting_c;
    wire signed [31:0] lp_err = raw_target - position_command;
    wire [4:0] lp_shift = (position_lowpass_setting > 16'h001f) ? 5'h1f :
        position_lowpass_setting[4:0];
    wire signed [31:0] lp_step = lp_err >>> lp_shift;
    wire signed [63:0] ramp_prod = (move_goal - move_start) * $signed({16'h0000, ramp_count});

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pa_q <= 1'b0;
            pb_q <= 1'b0;
            trig_q <= 1'b0;
            state <= st_idle;
            raw_target <= 32'sh00000000;
            move_start <= 32'sh00000000;
            move_goal <= 32'sh00000000;
            ramp_count <= 16'h0000;
            position_command <= 32'sh00000000;
            active_loop <= `SMSPS_LOOP_POS_PULSE;
            use_analog_command <= 1'b0;
            setpoint_index <= 2'h0;
            move_busy <= 1'b0;
        end else begin
            pa_q <= pulse_a;
            pb_q <= pulse_b;
            trig_q <= command_trigger_input;
            active_loop <= next_loop;
            use_analog_command <= next_analog;
            setpoint_index <= setpoint_select_inputs;
            if (gear_valid) begin
                raw_target <= raw_target + gear_step;
            end
            case (state)
                st_idle: begin
                    if (trig_rise && servo_enable && next_loop == `SMSPS_LOOP_POS_PRESET) begin
                        move_start <= raw_target;
                        move_goal <= preset_goal;
                        ramp_count <= 16'h0000;
                        state <= (ramp_len == 16'h0000) ? st_hold : st_ramp;
                    end
                end
                st_ramp: begin
                    // linear ramp over the s-curve time smooths preset steps only
                    ramp_count <= ramp_count + 16'h0001;
                    raw_target <= move_start +
                        $signed(ramp_prod[31:0]) / $signed({16'h0000, ramp_len});
                    if (ramp_count == ramp_len) begin
                        state <= st_hold;
                    end
                end
                st_hold: begin
                    raw_target <= move_goal;
                    state <= st_idle;
                end
                default: state <= st_idle;
            endcase
            move_busy <= (state != st_idle);
            if (position_lowpass_setting == 16'h0000 || lp_step == 32'sh00000000) begin
                position_command <= raw_target;
            end else begin
                position_command <= position_command + lp_step;
            end
        end
    end

    // mode code freezes once after reset, so rewrites wait for a power cycle
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            active_mode <= `SMSPS_MODE_PT;
            mode_latched <= 1'b0;
        end else if (!mode_latched) begin
            active_mode <= mode_code_setting;
            mode_latched <= 1'b1;
        end
    end

    // axi4-lite slave: address and data taken in either order
    wire wr_go = have_aw && have_w && !s_axi_bvalid;
    wire [31:0] mode_merged = merge({28'h0, mode_code_setting}, wa_data, wa_strb);

    // the stored code survives nrst, which stands in for the power cycle that makes it live
    always @(posedge clock) begin
        if (wr_go && {wa_addr[11:2], 2'b00} == `SMSPS_REG_MODE) begin
            mode_code_setting <= mode_merged[3:0];
        end
    end
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SMSPS_AXI_OKAY;
            have_aw <= 1'b0;
            have_w <= 1'b0;
            wa_addr <= 12'h000;
            wa_data <= 32'h00000000;
            wa_strb <= 4'h0;
            gear_numerator <= `SMSPS_GEAR_RESET;
            gear_denominator <= `SMSPS_GEAR_RESET;
            position_lowpass_setting <= 16'h0000;
            scurve_setting_a <= 16'h0000;
            scurve_setting_b <= 16'h0000;
            scurve_setting_c <= 16'h0000;
            config_bits <= 3'h0;
        end else begin
            s_axi_awready <= !have_aw && s_axi_awvalid && !s_axi_awready;
            s_axi_wready <= !have_w && s_axi_wvalid && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw <= 1'b1;
                wa_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w <= 1'b1;
                wa_data <= s_axi_wdata;
                wa_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                have_aw <= 1'b0;
                have_w <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SMSPS_AXI_OKAY;
                case ({wa_addr[11:2], 2'b00})
                    // stored above at any servo_enable level; the live code stays the old one until a power cycle
                    `SMSPS_REG_MODE: s_axi_bresp <= `SMSPS_AXI_OKAY;
                    `SMSPS_REG_GEAR_NUM: gear_numerator <= wa_data[15:0];
                    `SMSPS_REG_GEAR_DEN: gear_denominator <= wa_data[15:0];
                    `SMSPS_REG_LOWPASS: position_lowpass_setting <= wa_data[15:0];
                    `SMSPS_REG_SCURVE_A: scurve_setting_a <= wa_data[15:0];
                    `SMSPS_REG_SCURVE_B: scurve_setting_b <= wa_data[15:0];
                    `SMSPS_REG_SCURVE_C: scurve_setting_c <= wa_data[15:0];
                    `SMSPS_REG_CONFIG: config_bits <= wa_data[2:0];
                    default: begin
                        if (!is_preset(wa_addr)) begin
                            s_axi_bresp <= `SMSPS_AXI_SLVERR;
                        end
                    end
                endcase
            end
        end
    end

    // preset storage as a generate of word registers
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_preset
            always @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    preset_mem[g] <= 32'h00000000;
                end else if (wr_go && is_preset(wa_addr) && wa_addr[5:2] == g) begin
                    preset_mem[g] <= merge(preset_mem[g], wa_data, wa_strb);
                end
            end
        end
    endgenerate

    // read channel: one word per request, unmapped answers slverr with zero
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SMSPS_AXI_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `SMSPS_AXI_OKAY;
                case ({s_axi_araddr[11:2], 2'b00})
                    `SMSPS_REG_MODE: s_axi_rdata <= {28'h0, mode_code_setting};
                    `SMSPS_REG_GEAR_NUM: s_axi_rdata <= {16'h0, gear_numerator};
                    `SMSPS_REG_GEAR_DEN: s_axi_rdata <= {16'h0, gear_denominator};
                    `SMSPS_REG_LOWPASS: s_axi_rdata <= {16'h0, position_lowpass_setting};
                    `SMSPS_REG_SCURVE_A: s_axi_rdata <= {16'h0, scurve_setting_a};
                    `SMSPS_REG_SCURVE_B: s_axi_rdata <= {16'h0, scurve_setting_b};
                    `SMSPS_REG_SCURVE_C: s_axi_rdata <= {16'h0, scurve_setting_c};
                    `SMSPS_REG_CONFIG: s_axi_rdata <= {29'h0, config_bits};
                    `SMSPS_REG_STATUS: s_axi_rdata <= {24'h0, move_busy, active_loop,
                        active_mode};
                    `SMSPS_REG_TARGET: s_axi_rdata <= position_command;
                    default: begin
                        if (is_preset(s_axi_araddr)) begin
                            s_axi_rdata <= preset_mem[s_axi_araddr[5:2]];
                        end else begin
                            s_axi_rdata <= 32'h00000000;
                            s_axi_rresp <= `SMSPS_AXI_SLVERR;
                        end
                    end
                endcase
            end
        end
    end
endmodule // smsps_top

//--- sim/smsps_props.sv
// checker: bus handshake and loop select properties of the mode select block
`timescale 1ns/10ps
module smsps_props (
    // clock and reset
    input logic clock,
    input logic nrst,
    // register bus
    input logic s_axi_awready,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // control loop side
    input logic servo_enable,
    input logic [2:0] active_loop,
    input logic use_analog_command,
    input logic signed [31:0] position_command,
    input logic move_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    aw_one_cycle_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    w_one_cycle_a: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready longer than one cycle");
    bresp_held_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid kept after handshake");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late after read address");
    rdata_held_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid kept after handshake");
    analog_loop_a: assert property (use_analog_command |-> active_loop[2:1] == 2'h1)
        else $error("analog command outside velocity or torque loop");
    idle_position_a: assert property ((!servo_enable && !move_busy) [*4] |=> $stable(position_command))
        else $error("position moved while servo disabled");
    loop_hold_a: assert property (active_loop[1] [*4] |=> $stable(position_command))
        else $error("position moved in velocity or torque loop");
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property ($fell(move_busy));
    cover property (active_loop == 3'h0 && $changed(position_command));
endmodule // smsps_props

bind smsps_top smsps_props u_props (.*);

//--- sim/smsps_host_model.sv
// model of the motion controller driving the command pulse pins
`timescale 1ns/10ps
module smsps_host_model (
    // clock
    input logic clock,
    // command pulse pins
    output logic pulse_a = 1'b0,
    output logic pulse_b = 1'b0
);
    logic [1:0] phase = 2'h0;
    // counts are spaced well apart so the drive never sees two in one clock
    task automatic send(input logic [1:0] fmt, input int n, input logic neg);
        repeat (n) begin
            @(posedge clock);
            if (fmt == 2'h0) begin
                phase = neg ? phase - 2'h1 : phase + 2'h1;
                pulse_a <= phase[1] ^ phase[0];
                pulse_b <= phase[1];
            end else if (fmt == 2'h1) begin
                pulse_b <= neg;
                @(posedge clock);
                pulse_a <= 1'b1;
            end else begin
                pulse_a <= !neg;
                pulse_b <= neg;
            end
            repeat (2) @(posedge clock);
            if (fmt != 2'h0) begin
                pulse_a <= 1'b0;
                pulse_b <= 1'b0;
            end
            repeat (2) @(posedge clock);
        end
        repeat (8) @(posedge clock);
    endtask
endmodule // smsps_host_model

//--- sim/testbench.sv
// self-checking bench for mode select and position scaling
`timescale 1ns/10ps
`include "smsps_map.vh"
module testbench;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, setpoint_index, setpoint_select_inputs = 2'h0;
    logic pulse_a, pulse_b, servo_enable = 1'b0, mode_switch_input = 1'b0;
    logic command_trigger_input = 1'b0, use_analog_command, move_busy;
    logic [2:0] preset_select_inputs = 3'h0, active_loop;
    logic signed [31:0] position_command, expect_pos;
    // expected loop per mode code, one nibble per code: switch low, switch high
    localparam logic [43:0] LOOP_A = 44'h21100323210;
    localparam logic [43:0] LOOP_B = 44'h33232323210;
    int miscompares = 0, tests_run = 0, c, s, prev = 0;
    smsps_top dut (.*);
    smsps_host_model host (.clock(clock), .pulse_a(pulse_a), .pulse_b(pulse_b));
    always #25 clock = ~clock;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("write response", s_axi_bresp, er);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check("read data", s_axi_rdata, exp);
        check("read response", s_axi_rresp, er);
    endtask
    // reset doubles as the power cycle that makes a new mode code live
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
    endtask
    task automatic wait_busy(input logic v);
        int i;
        for (i = 0; i < 200 && move_busy !== v; i++) @(posedge clock);
        check("move busy", move_busy, v);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        miscompares++;
        conclude();
    end
    initial begin
        do_reset();
        rd(`SMSPS_REG_GEAR_NUM, 32'h1, 2'h0);
        rd(`SMSPS_REG_GEAR_DEN, 32'h1, 2'h0);
        rd(12'h030, 32'h0, 2'h2);
        wr(12'h034, 32'h5, 2'h2);
        $display("test registers done");
        for (c = 0; c < 11; c++) begin
            servo_enable <= 1'b0;
            mode_switch_input <= 1'b0;
            wr(`SMSPS_REG_MODE, c, 2'h0);
            rd(`SMSPS_REG_MODE, c, 2'h0);
            check("loop before power cycle", active_loop, LOOP_A[prev*4 +: 3]);
            do_reset();
            for (s = 0; s < 2; s++) begin
                mode_switch_input <= s[0];
                repeat (3) @(posedge clock);
                check("active loop", active_loop, s ? LOOP_B[c*4 +: 3] : LOOP_A[c*4 +: 3]);
            end
            if (c > 1 && c < 6) check("analog select", use_analog_command, c < 4);
            check("setpoint index", setpoint_index, setpoint_select_inputs);
            rd(`SMSPS_REG_STATUS, {25'h0, LOOP_B[c*4 +: 3], 4'(c)}, 2'h0);
            prev = c;
        end
        $display("test modes done");
        wr(`SMSPS_REG_MODE, 32'h0, 2'h0);
        do_reset();
        wr(`SMSPS_REG_GEAR_NUM, 32'h3, 2'h0);
        wr(`SMSPS_REG_GEAR_DEN, 32'h2, 2'h0);
        servo_enable <= 1'b1;
        expect_pos = 32'h0;
        for (c = 0; c < 3; c++) begin
            wr(`SMSPS_REG_CONFIG, c, 2'h0);
            host.send(c[1:0], 4, 1'b0);
            expect_pos += 32'h6;
            check("pulse position", position_command, expect_pos);
        end
        host.send(2'h2, 4, 1'b1);
        check("reverse position", position_command, 32'hc);
        servo_enable <= 1'b0;
        host.send(2'h2, 4, 1'b0);
        check("disabled position", position_command, 32'hc);
        $display("test pulses done");
        wr(`SMSPS_REG_MODE, 32'h1, 2'h0);
        do_reset();
        wr(`SMSPS_REG_GEAR_NUM, 32'h2, 2'h0);
        wr(`SMSPS_REG_SCURVE_A, 32'h8, 2'h0);
        wr(12'h068, 32'h1, 2'h0);
        wr(12'h06c, 32'hfa, 2'h0);
        preset_select_inputs <= 3'h5;
        servo_enable <= 1'b1;
        @(posedge clock);
        command_trigger_input <= 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        check("preset position", position_command, 32'h5014);
        $display("test preset done");
        conclude();
    end
endmodule // testbench
